// *** src/config_overlay_pkg.sv ***
// Constants for the configuration overlay command handler
package config_overlay_pkg;
	// APB register byte offsets
	localparam logic [7:0] OFS_FEATURE = 8'h00;
	localparam logic [7:0] OFS_SECCNT  = 8'h04;
	localparam logic [7:0] OFS_SECNUM  = 8'h08;
	localparam logic [7:0] OFS_CYLLO   = 8'h0C;
	localparam logic [7:0] OFS_CYLHI   = 8'h10;
	localparam logic [7:0] OFS_CMDSTAT = 8'h14;
	localparam logic [7:0] OFS_ERROR   = 8'h18;
	localparam logic [7:0] OFS_DATA    = 8'h1C;
	localparam logic [7:0] OFS_DEVCTL  = 8'h20;
	localparam logic [7:0] OFS_COND    = 8'h24;
	localparam logic [7:0] OFS_CAPS    = 8'h28;
	localparam logic [7:0] OFS_MAXLO   = 8'h2C;
	localparam logic [7:0] OFS_MAXHI   = 8'h30;
	// Command and subcommands
	localparam logic [7:0] CMD_OVERLAY   = 8'hB1;
	localparam logic [7:0] SUB_RESTORE   = 8'hC0;
	localparam logic [7:0] SUB_FREEZE    = 8'hC1;
	localparam logic [7:0] SUB_IDENTIFY  = 8'hC2;
	localparam logic [7:0] SUB_SET       = 8'hC3;
	// Abort reason codes
	localparam logic [7:0] RSN_FROZEN    = 8'h01;
	localparam logic [7:0] RSN_SECLOCK   = 8'h02;
	localparam logic [7:0] RSN_MODIFIED  = 8'h03;
	localparam logic [7:0] RSN_DISABLE   = 8'h04;
	localparam logic [7:0] RSN_MAXLOCK   = 8'h05;
	localparam logic [7:0] RSN_PROTAREA  = 8'h06;
	localparam logic [7:0] RSN_UNSUPP    = 8'h07;
	localparam logic [7:0] RSN_BADSUB    = 8'h08;
	localparam logic [7:0] RSN_OTHER     = 8'hFF;
	// Status, error and control bit positions
	localparam int STS_BSY  = 7;
	localparam int STS_RDY  = 6;
	localparam int STS_DRQ  = 3;
	localparam int STS_ERR  = 0;
	localparam int ERR_ABRT = 2;
	localparam int CTL_SRST = 2;
	localparam int FEAT_SECURITY = 3;
	// Condition register bits
	localparam int CND_SECLOCK  = 0;
	localparam int CND_SECEN    = 1;
	localparam int CND_MAXLOCK  = 2;
	localparam int CND_PROTAREA = 3;
	localparam int CND_UNSUPP   = 4;
	// Overlay structure layout
	localparam logic [15:0] OVL_REVISION  = 16'h0001;
	localparam logic [7:0]  OVL_SIGNATURE = 8'hA5;
	localparam logic [7:0]  OVL_LAST_WORD = 8'hFF;
	localparam logic [7:0]  WORD_LBA      = 8'h03;
	localparam logic [7:0]  WORD_FEAT     = 8'h07;
	// Full capability set after power-on
	localparam logic [2:0]  FULL_MDMA   = 3'h7;
	localparam logic [5:0]  FULL_UDMA   = 6'h3F;
	localparam logic [8:0]  FULL_FEAT   = 9'h1FF;
	localparam logic [47:0] FULL_MAXLBA = 48'h0000_0FFF_FFFF;
	localparam logic [7:0]  RESET_BYTE  = 8'h00;

	function automatic logic [7:0] byteSum16(input logic [15:0] w);
		byteSum16 = w[7:0] + w[15:8];
	endfunction

	// Checksum byte of the full overlay structure
	function automatic logic [7:0] fullChecksum();
		logic [7:0] s;
		s = byteSum16(OVL_REVISION) + byteSum16({13'h0000, FULL_MDMA});
		s = s + byteSum16({10'h000, FULL_UDMA}) + byteSum16(FULL_MAXLBA[15:0]);
		s = s + byteSum16(FULL_MAXLBA[31:16]) + byteSum16(FULL_MAXLBA[47:32]);
		s = s + byteSum16({7'h00, FULL_FEAT}) + OVL_SIGNATURE;
		fullChecksum = 8'h00 - s;
	endfunction

	localparam logic [7:0] IDENT_CKSUM = fullChecksum();

	// True for the four overlay subcommands
	function automatic logic isSub(input logic [7:0] f);
		isSub = f == SUB_RESTORE || f == SUB_FREEZE || f == SUB_IDENTIFY || f == SUB_SET;
	endfunction
endpackage

// *** src/config_overlay_cmd.sv ***
// Configuration overlay command handler with APB taskfile
//
// Behaviour
// - Opcode B1h selects overlay; features pick subcommand
// - Decode C0h restore, C1h freeze, C2h identify, C3h set
// - Reserved subcommand aborts with reason 08h
// - Restore returns active capabilities to full set
// - After freeze, all overlay subcommands abort 01h
// - Frozen state cleared only by power-on reset
// - Identify returns 512 bytes by PIO data-in
// - Identify full set; normal identify shows reduced
// - Set clears capability bits of identify words
// - Received bits absent from full set ignored
// - Abort gives reason, word, low bit location
// - Sector number carries bit location bits 15:8
// - Reason codes 02h to 07h and FFh
// - Overlay word 0 holds revision 0001h
// - Words 1 and 2 flag DMA modes
// - Max LBA change under protected area aborts
// - Word 7 flags feature set support
// - Disabling enabled security aborts with 04h
// - Word 255 holds signature A5h and checksum
// - Checksum makes full byte sum zero
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module config_overlay_cmd (
	// Clock and resets
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        porRst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Host completion and capability outputs
	output logic             intrq,
	output logic      [2:0]  activeMdma,
	output logic      [5:0]  activeUdma,
	output logic      [8:0]  activeFeat,
	output logic      [47:0] activeMaxLba
);
	import config_overlay_pkg::*;
	typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_DIN, ST_DOUT, ST_CHECK} state_e;
	state_e      state;
	logic [7:0]  featReg, secCnt, secNum, cylLo, cylHi, statusReg, errorReg;
	logic [7:0]  wordIdx, byteSum;
	logic [4:0]  condReg;
	logic        frozen, modified;
	logic [2:0]  rxMdma;
	logic [5:0]  rxUdma;
	logic [8:0]  rxFeat;
	logic [47:0] rxLba;
	logic        wrEn, rdEn, softRst;
	// Outcome of an execution or check step
	logic        doAbort, doFreeze, doRestore, doApply, doDin, doDout;
	logic [7:0]  next_reason, next_word;
	logic [15:0] next_mask;
	assign wrEn    = psel & penable & pwrite;
	assign rdEn    = psel & penable & ~pwrite;
	assign pready  = 1'b1;
	assign softRst = wrEn && paddr == OFS_DEVCTL && pwdata[CTL_SRST];
	// Full overlay structure word
	function automatic logic [15:0] identWord(input logic [7:0] idx);
		if (idx == 8'h00) begin
			identWord = OVL_REVISION;
		end else if (idx == 8'h01) begin
			identWord = {13'h0000, FULL_MDMA};
		end else if (idx == 8'h02) begin
			identWord = {10'h000, FULL_UDMA};
		end else if (idx == 8'h03) begin
			identWord = FULL_MAXLBA[15:0];
		end else if (idx == 8'h04) begin
			identWord = FULL_MAXLBA[31:16];
		end else if (idx == 8'h05) begin
			identWord = FULL_MAXLBA[47:32];
		end else if (idx == WORD_FEAT) begin
			identWord = {7'h00, FULL_FEAT};
		end else if (idx == OVL_LAST_WORD) begin
			identWord = {IDENT_CKSUM, OVL_SIGNATURE};
		end else begin
			identWord = 16'h0000;
		end
	endfunction

	// Decision logic for execute and check steps
	always_comb begin
		doAbort     = 1'b0;
		doFreeze    = 1'b0;
		doRestore   = 1'b0;
		doApply     = 1'b0;
		doDin       = 1'b0;
		doDout      = 1'b0;
		next_reason = RESET_BYTE;
		next_word   = RESET_BYTE;
		next_mask   = 16'h0000;
		if (state == ST_EXEC) begin
			if (!isSub(featReg)) begin
				doAbort     = 1'b1;
				next_reason = RSN_BADSUB;
			end else if (frozen) begin
				doAbort     = 1'b1;
				next_reason = RSN_FROZEN;
			end else if (condReg[CND_UNSUPP]) begin
				doAbort     = 1'b1;
				next_reason = RSN_UNSUPP;
			end else if (featReg == SUB_FREEZE) begin
				doFreeze = 1'b1;
			end else if (featReg == SUB_IDENTIFY) begin
				doDin = 1'b1;
			end else if (condReg[CND_SECLOCK]) begin
				doAbort     = 1'b1;
				next_reason = RSN_SECLOCK;
			end else if (condReg[CND_MAXLOCK]) begin
				doAbort     = 1'b1;
				next_reason = RSN_MAXLOCK;
			end else if (featReg == SUB_RESTORE) begin
				if (condReg[CND_PROTAREA] && activeMaxLba != FULL_MAXLBA) begin
					doAbort     = 1'b1;
					next_reason = RSN_PROTAREA;
					next_word   = WORD_LBA;
				end else begin
					doRestore = 1'b1;
				end
			end else if (modified) begin
				doAbort     = 1'b1;
				next_reason = RSN_MODIFIED;
			end else begin
				doDout = 1'b1;
			end
		end else if (state == ST_CHECK) begin
			if (byteSum != 8'h00) begin
				doAbort     = 1'b1;
				next_reason = RSN_OTHER;
				next_word   = OVL_LAST_WORD;
			end else if (condReg[CND_PROTAREA] && rxLba != activeMaxLba) begin
				doAbort     = 1'b1;
				next_reason = RSN_PROTAREA;
				next_word   = WORD_LBA;
			end else if (condReg[CND_SECEN] && activeFeat[FEAT_SECURITY]
				&& !rxFeat[FEAT_SECURITY]) begin
				doAbort     = 1'b1;
				next_reason = RSN_DISABLE;
				next_word   = WORD_FEAT;
				next_mask   = 16'h0001 << FEAT_SECURITY;
			end else begin
				doApply = 1'b1;
			end
		end
	end
	// Command sequencing and taskfile
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state     <= ST_IDLE;
			featReg   <= RESET_BYTE;
			secCnt    <= RESET_BYTE;
			secNum    <= RESET_BYTE;
			cylLo     <= RESET_BYTE;
			cylHi     <= RESET_BYTE;
			statusReg <= 8'h40;
			errorReg  <= RESET_BYTE;
			wordIdx   <= RESET_BYTE;
			byteSum   <= RESET_BYTE;
			intrq     <= 1'b0;
		end else if (softRst) begin
			state     <= ST_IDLE;
			statusReg <= 8'h40;
			errorReg  <= RESET_BYTE;
			intrq     <= 1'b0;
		end else begin
			if (rdEn && paddr == OFS_CMDSTAT) begin
				intrq <= 1'b0;
			end
			case (state)
				ST_IDLE: begin
					if (wrEn && paddr == OFS_FEATURE) begin
						featReg <= pwdata[7:0];
					end else if (wrEn && paddr == OFS_SECCNT) begin
						secCnt <= pwdata[7:0];
					end else if (wrEn && paddr == OFS_SECNUM) begin
						secNum <= pwdata[7:0];
					end else if (wrEn && paddr == OFS_CYLLO) begin
						cylLo <= pwdata[7:0];
					end else if (wrEn && paddr == OFS_CYLHI) begin
						cylHi <= pwdata[7:0];
					end else if (wrEn && paddr == OFS_CMDSTAT
						&& pwdata[7:0] == CMD_OVERLAY) begin
						state     <= ST_EXEC;
						statusReg <= 8'h80;
						errorReg  <= RESET_BYTE;
						intrq     <= 1'b0;
					end
				end
				ST_EXEC, ST_CHECK: begin
					if (doAbort) begin
						secCnt    <= next_reason;
						cylHi     <= next_word;
						cylLo     <= next_mask[7:0];
						secNum    <= next_mask[15:8];
						errorReg  <= 8'h01 << ERR_ABRT;
						statusReg <= (8'h01 << STS_RDY) | (8'h01 << STS_ERR);
						intrq     <= 1'b1;
						state     <= ST_IDLE;
					end else if (doDin || doDout) begin
						statusReg <= (8'h01 << STS_RDY) | (8'h01 << STS_DRQ);
						wordIdx   <= RESET_BYTE;
						byteSum   <= RESET_BYTE;
						intrq     <= doDin;
						state     <= doDin ? ST_DIN : ST_DOUT;
					end else begin
						statusReg <= 8'h01 << STS_RDY;
						intrq     <= 1'b1;
						state     <= ST_IDLE;
					end
				end
				ST_DIN: begin
					if (rdEn && paddr == OFS_DATA) begin
						wordIdx <= wordIdx + 8'h01;
						if (wordIdx == OVL_LAST_WORD) begin
							statusReg <= 8'h01 << STS_RDY;
							state     <= ST_IDLE;
						end
					end
				end
				ST_DOUT: begin
					if (wrEn && paddr == OFS_DATA) begin
						wordIdx <= wordIdx + 8'h01;
						byteSum <= byteSum + byteSum16(pwdata[15:0]);
						if (wordIdx == OVL_LAST_WORD) begin
							statusReg <= 8'h80;
							state     <= ST_CHECK;
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
	// Received overlay words
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rxMdma <= 3'h0;
			rxUdma <= 6'h00;
			rxFeat <= 9'h000;
			rxLba  <= 48'h0;
		end else if (state == ST_DOUT && wrEn && paddr == OFS_DATA) begin
			if (wordIdx == 8'h01) begin
				rxMdma <= pwdata[2:0];
			end else if (wordIdx == 8'h02) begin
				rxUdma <= pwdata[5:0];
			end else if (wordIdx == 8'h03) begin
				rxLba[15:0] <= pwdata[15:0];
			end else if (wordIdx == 8'h04) begin
				rxLba[31:16] <= pwdata[15:0];
			end else if (wordIdx == 8'h05) begin
				rxLba[47:32] <= pwdata[15:0];
			end else if (wordIdx == WORD_FEAT) begin
				rxFeat <= pwdata[8:0];
			end
		end
	end
	// Drive condition register, written by firmware
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			condReg <= 5'h00;
		end else if (wrEn && paddr == OFS_COND) begin
			condReg <= pwdata[4:0];
		end
	end
	// Overlay and freeze state, kept across hardware and soft reset
	always_ff @(posedge ref_clk or posedge porRst) begin
		if (porRst) begin
			frozen       <= 1'b0;
			modified     <= 1'b0;
			activeMdma   <= FULL_MDMA;
			activeUdma   <= FULL_UDMA;
			activeFeat   <= FULL_FEAT;
			activeMaxLba <= FULL_MAXLBA;
		end else if (!sys_rst && !softRst) begin
			if (doFreeze) begin
				frozen <= 1'b1;
			end
			if (doRestore) begin
				modified     <= 1'b0;
				activeMdma   <= FULL_MDMA;
				activeUdma   <= FULL_UDMA;
				activeFeat   <= FULL_FEAT;
				activeMaxLba <= FULL_MAXLBA;
			end else if (doApply) begin
				modified     <= 1'b1;
				activeMdma   <= rxMdma & FULL_MDMA;
				activeUdma   <= rxUdma & FULL_UDMA;
				activeFeat   <= rxFeat & FULL_FEAT;
				activeMaxLba <= (rxLba > FULL_MAXLBA) ? FULL_MAXLBA : rxLba;
			end
		end
	end
	// APB read mux and error answer
	always_comb begin
		prdata  = 32'h0000_0000;
		pslverr = 1'b0;
		if (paddr == OFS_FEATURE) begin
			prdata[7:0] = errorReg;
		end else if (paddr == OFS_SECCNT) begin
			prdata[7:0] = secCnt;
		end else if (paddr == OFS_SECNUM) begin
			prdata[7:0] = secNum;
		end else if (paddr == OFS_CYLLO) begin
			prdata[7:0] = cylLo;
		end else if (paddr == OFS_CYLHI) begin
			prdata[7:0] = cylHi;
		end else if (paddr == OFS_CMDSTAT) begin
			prdata[7:0] = statusReg;
		end else if (paddr == OFS_ERROR) begin
			prdata[7:0] = errorReg;
		end else if (paddr == OFS_DATA) begin
			prdata[15:0] = (state == ST_DIN) ? identWord(wordIdx) : 16'h0000;
		end else if (paddr == OFS_DEVCTL) begin
			prdata[1:0] = {modified, frozen};
		end else if (paddr == OFS_COND) begin
			prdata[4:0] = condReg;
		end else if (paddr == OFS_CAPS) begin
			prdata[17:0] = {activeFeat, activeUdma, activeMdma};
		end else if (paddr == OFS_MAXLO) begin
			prdata = activeMaxLba[31:0];
		end else if (paddr == OFS_MAXHI) begin
			prdata[15:0] = activeMaxLba[47:32];
		end else begin
			pslverr = psel & penable;
		end
	end

	bad_sub_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state == ST_EXEC && !isSub(featReg) && !softRst
		|=> secCnt == RSN_BADSUB && statusReg[STS_ERR])
		else $error("reserved subcommand not aborted with 08h");
	frozen_abort_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state == ST_EXEC && isSub(featReg) && frozen && !softRst |=> secCnt == RSN_FROZEN)
		else $error("frozen overlay subcommand not aborted with 01h");
	freeze_hold_a: assert property (@(posedge ref_clk) disable iff (porRst)
		frozen |=> frozen)
		else $error("frozen state lost without power-on reset");
	restore_full_a: assert property (@(posedge ref_clk) disable iff (porRst)
		doRestore && !sys_rst && !softRst |=> activeFeat == FULL_FEAT && !modified)
		else $error("restore did not return full capabilities");
	ident_rev_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state == ST_DIN && wordIdx == 8'h00 && paddr == OFS_DATA
		|-> prdata[15:0] == OVL_REVISION)
		else $error("overlay word 0 is not revision 0001h");
	subset_a: assert property (@(posedge ref_clk) disable iff (porRst)
		(activeFeat & ~FULL_FEAT) == 9'h000 && (activeUdma & ~FULL_UDMA) == 6'h00)
		else $error("active capability outside full set");
	abort_flags_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		doAbort && !softRst |=> errorReg[ERR_ABRT] && statusReg[STS_ERR]
		&& !statusReg[STS_BSY] && intrq && state == ST_IDLE)
		else $error("abort did not set error flags and complete");
	sec_disable_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state == ST_CHECK && byteSum == 8'h00 && next_reason == RSN_DISABLE && !softRst
		|=> cylHi == WORD_FEAT && cylLo == 8'h08 && secNum == 8'h00)
		else $error("security disable abort codes wrong");
	checksum_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		state == ST_CHECK && byteSum != 8'h00 && !softRst |=> secCnt == RSN_OTHER)
		else $error("bad checksum not aborted");
endmodule

// *** test/ata_host_model.sv ***
// Host controller model that drives the taskfile over the register bus
`timescale 1ns/1ps
module ata_host_model (
	// Clock
	input  wire logic        ref_clk,
	// Register bus master
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	import config_overlay_pkg::*;
	logic [31:0] rdata;
	logic        rerr;

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'hFF;
		pwdata = 32'h0;
	end

	// Entered just after a rising edge; leaves one idle edge behind
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
		@(posedge ref_clk);
	endtask

	task automatic command(input logic [7:0] sub);
		xfer(1'b1, OFS_FEATURE, {24'h0, sub});
		xfer(1'b1, OFS_CMDSTAT, {24'h0, CMD_OVERLAY});
	endtask

	// Word 255 is closed with signature and checksum; bad spoils it
	task automatic sendOverlay(input logic [15:0] w [256], input logic bad);
		logic [7:0] s;
		s = OVL_SIGNATURE;
		for (int i = 0; i < 255; i++) s = s + w[i][7:0] + w[i][15:8];
		for (int i = 0; i < 255; i++) xfer(1'b1, OFS_DATA, {16'h0, w[i]});
		xfer(1'b1, OFS_DATA, {16'h0, 8'h00 - s + {7'h00, bad}, OVL_SIGNATURE});
	endtask

	task automatic readOverlay(output logic [15:0] w [256]);
		for (int i = 0; i < 256; i++) begin
			xfer(1'b0, OFS_DATA, 32'h0);
			w[i] = rdata[15:0];
		end
	endtask
endmodule

// *** test/config_overlay_cmd_bench.sv ***
// Self-checking bench for the configuration overlay command handler
`timescale 1ns/1ps
module config_overlay_cmd_bench;
	import config_overlay_pkg::*;
	typedef logic [15:0] ovl_t [256];
	logic        ref_clk;
	logic        sysRst;
	logic        porRst;
	logic        psel, penable, pwrite, pready, pslverr, intrq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [2:0]  activeMdma;
	logic [5:0]  activeUdma;
	logic [8:0]  activeFeat;
	logic [47:0] activeMaxLba;
	int          num_errors;
	int          n_checks;
	logic [31:0] seed;
	logic [7:0]  sub;
	ovl_t        ovl;
	logic [7:0]  rsnTab [3] = '{RSN_SECLOCK, RSN_MAXLOCK, RSN_UNSUPP};
	int          bitTab [3] = '{CND_SECLOCK, CND_MAXLOCK, CND_UNSUPP};
	logic [15:0] fw1, fw2, fw3, fw7;

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	config_overlay_cmd u_config_overlay_cmd (.ref_clk(ref_clk), .sys_rst(sysRst),
		.porRst(porRst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .intrq(intrq),
		.activeMdma(activeMdma), .activeUdma(activeUdma), .activeFeat(activeFeat),
		.activeMaxLba(activeMaxLba));

	ata_host_model u_ata_host_model (.ref_clk(ref_clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [15:0] expWord(input int i);
		case (i)
			0: expWord = 16'h0001;
			1: expWord = {13'h0000, FULL_MDMA};
			2: expWord = {10'h000, FULL_UDMA};
			3: expWord = FULL_MAXLBA[15:0];
			4: expWord = FULL_MAXLBA[31:16];
			5: expWord = FULL_MAXLBA[47:32];
			7: expWord = {7'h00, FULL_FEAT};
			default: expWord = 16'h0000;
		endcase
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out;
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		u_ata_host_model.xfer(1'b0, a, 32'h0);
		chk(u_ata_host_model.rdata, exp);
	endtask

	// Completion interrupt within a bounded wait
	task automatic waitDone;
		int n;
		n = 0;
		while (intrq !== 1'b1 && n < 50) begin
			@(posedge ref_clk);
			n++;
		end
		chk({31'h0, intrq}, 32'h1);
	endtask

	task automatic run(input logic [7:0] s);
		u_ata_host_model.command(s);
		waitDone();
	endtask

	task automatic chkAbort(input logic [7:0] rsn, input logic [7:0] wd, input logic [15:0] loc);
		rdChk(OFS_CMDSTAT, 32'h41);
		rdChk(OFS_ERROR, 32'h1 << ERR_ABRT);
		rdChk(OFS_SECCNT, {24'h0, rsn});
		rdChk(OFS_CYLHI, {24'h0, wd});
		rdChk(OFS_CYLLO, {24'h0, loc[7:0]});
		rdChk(OFS_SECNUM, {24'h0, loc[15:8]});
	endtask

	task automatic identify;
		logic [7:0] s;
		s = 8'h00;
		run(SUB_IDENTIFY);
		rdChk(OFS_CMDSTAT, 32'h48);
		u_ata_host_model.readOverlay(ovl);
		for (int i = 0; i < 255; i++) chk({16'h0, ovl[i]}, {16'h0, expWord(i)});
		for (int i = 0; i < 256; i++) s = s + ovl[i][7:0] + ovl[i][15:8];
		chk({24'h0, ovl[255][7:0]}, 32'hA5);
		chk({24'h0, s}, 32'h0);
		rdChk(OFS_CMDSTAT, 32'h40);
	endtask

	task automatic sendSet(input logic [15:0] w1, w2, w3, w7, input logic bad);
		for (int i = 0; i < 256; i++) ovl[i] = expWord(i);
		ovl[1] = w1;
		ovl[2] = w2;
		ovl[3] = w3;
		ovl[7] = w7;
		u_ata_host_model.command(SUB_SET);
		rdChk(OFS_CMDSTAT, 32'h48);
		u_ata_host_model.sendOverlay(ovl, bad);
		waitDone();
	endtask

	task automatic setCond(input logic [4:0] v);
		u_ata_host_model.xfer(1'b1, OFS_COND, {27'h0, v});
	endtask

	task automatic rstPulse(input logic por);
		sysRst <= 1'b1;
		porRst <= por;
		repeat (2) @(posedge ref_clk);
		sysRst <= 1'b0;
		porRst <= 1'b0;
		@(posedge ref_clk);
	endtask

	initial begin
		repeat (40000) @(posedge ref_clk);
		num_errors++;
		close_out();
	end

	initial begin
		sysRst = 1'b1;
		porRst = 1'b1;
		num_errors = 0;
		n_checks = 0;
		seed = 32'h5a7f;
		fw1 = expWord(1);
		fw2 = expWord(2);
		fw3 = expWord(3);
		fw7 = expWord(7);
		repeat (8) @(posedge ref_clk);
		sysRst <= 1'b0;
		porRst <= 1'b0;
		@(posedge ref_clk);
		chk({14'h0, activeFeat, activeUdma, activeMdma}, {14'h0, FULL_FEAT, FULL_UDMA, FULL_MDMA});
		rdChk(OFS_CMDSTAT, 32'h40);
		for (int k = 0; k < 8; k++) begin
			seed = lfsr(seed);
			sub = (k == 0) ? 8'hBF : (k == 1) ? 8'hC4 : (k == 2) ? 8'hFF : {1'b0, seed[6:0]};
			run(sub);
			chkAbort(RSN_BADSUB, 8'h00, 16'h0000);
		end
		identify();
		seed = lfsr(seed);
		sendSet({13'h1FFF, seed[2:0]}, {10'h3FF, seed[8:3]}, fw3 ^ 16'h0001,
			{7'h7F, seed[17:9]}, 1'b0);
		rdChk(OFS_CMDSTAT, 32'h40);
		rdChk(OFS_MAXLO, FULL_MAXLBA[31:0] ^ 32'h1);
		chk({14'h0, activeFeat, activeUdma, activeMdma}, {14'h0, seed[17:0]});
		identify();
		run(SUB_SET);
		chkAbort(RSN_MODIFIED, 8'h00, 16'h0000);
		run(SUB_RESTORE);
		rdChk(OFS_CMDSTAT, 32'h40);
		chk({14'h0, activeFeat, activeUdma, activeMdma}, {14'h0, FULL_FEAT, FULL_UDMA, FULL_MDMA});
		rdChk(OFS_MAXLO, FULL_MAXLBA[31:0]);
		rdChk(OFS_MAXHI, {16'h0, FULL_MAXLBA[47:32]});
		sendSet(fw1, fw2, fw3, fw7, 1'b1);
		chkAbort(RSN_OTHER, 8'hFF, 16'h0000);
		setCond(5'h08);
		sendSet(fw1, fw2, fw3 ^ 16'h0001, fw7, 1'b0);
		chkAbort(RSN_PROTAREA, WORD_LBA, 16'h0000);
		setCond(5'h02);
		sendSet(fw1, fw2, fw3, fw7 & ~16'h0008, 1'b0);
		chkAbort(RSN_DISABLE, WORD_FEAT, 16'h0008);
		for (int k = 0; k < 3; k++) begin
			setCond(5'h01 << bitTab[k]);
			run(SUB_SET);
			chkAbort(rsnTab[k], 8'h00, 16'h0000);
		end
		setCond(5'h00);
		u_ata_host_model.xfer(1'b0, 8'hFC, 32'h0);
		chk({31'h0, u_ata_host_model.rerr}, 32'h1);
		chk(u_ata_host_model.rdata, 32'h0);
		run(SUB_FREEZE);
		rdChk(OFS_CMDSTAT, 32'h40);
		for (int k = 0; k < 4; k++) begin
			run(SUB_RESTORE + 8'(k));
			chkAbort(RSN_FROZEN, 8'h00, 16'h0000);
		end
		rstPulse(1'b0);
		u_ata_host_model.xfer(1'b1, OFS_DEVCTL, 32'h4);
		run(SUB_IDENTIFY);
		chkAbort(RSN_FROZEN, 8'h00, 16'h0000);
		rdChk(OFS_DEVCTL, 32'h1);
		rstPulse(1'b1);
		identify();
		close_out();
	end
endmodule
